/* File: rtl/lpd_regs.svh */
/*
 Constants for the low-power DDR pin link: command codes, address fields,
 mode register layout, burst and latency counts.
 Assumes inclusion by bare name from lpd_pkg and from the two ends.
*/
`ifndef LPD_REGS_SVH
`define LPD_REGS_SVH

// Command codes on {row strobe, column strobe, write enable}, all low active
`define LPD_CMD_MRS 3'h0
`define LPD_CMD_REF 3'h1
`define LPD_CMD_PRE 3'h2
`define LPD_CMD_ACT 3'h3
`define LPD_CMD_WR 3'h4
`define LPD_CMD_RD 3'h5
`define LPD_CMD_BST 3'h6
`define LPD_CMD_NOP 3'h7

// Address and data widths of the x16 part
`define LPD_ADDR_W 13
`define LPD_DQ_W 16
`define LPD_LANES 2
`define LPD_AP_BIT 10
`define LPD_MEM_DEPTH 256

// Mode register fields and reset value
`define LPD_MR_W 7
`define LPD_MR_BL 2:0
`define LPD_MR_BT 3
`define LPD_MR_CL 6:4
`define LPD_MR_RST 7'h00
`define LPD_BANK_BASE 2'h0

// Burst length codes and beat counts
`define LPD_BL2 3'h1
`define LPD_BL4 3'h2
`define LPD_BL8 3'h3
`define LPD_BL16 3'h4
`define LPD_BEATS2 5'h02
`define LPD_BEATS4 5'h04
`define LPD_BEATS8 5'h08
`define LPD_BEATS16 5'h10

// CAS latency 2 code; wait in clk cycles from command to read preamble
`define LPD_CL2 3'h2
`define LPD_RD_WAIT_CL2 3'h3
`define LPD_RD_WAIT_CL3 3'h5

`endif

/* File: rtl/lpd_pkg.sv */
/*
 Types and small decode functions shared by both ends of the link.
 Assumes lpd_regs.svh is on the include path.
*/
`default_nettype none
`include "lpd_regs.svh"

package lpd_pkg;

   // Power states of the memory end
   typedef enum logic [2:0] {LPD_RUN, LPD_APD, LPD_PPD, LPD_SREF, LPD_DPD} lpd_pwr_e;

   // Requests taken by the controller end
   typedef enum logic [2:0] {
      LPD_Q_NOP, LPD_Q_ACT, LPD_Q_RD, LPD_Q_WR, LPD_Q_PRE, LPD_Q_REF, LPD_Q_MRS, LPD_Q_BST
   } lpd_req_e;

   // Beats per burst; reserved codes fall back to two beats
   function automatic logic [4:0] lpd_beats(input logic [2:0] code);
      unique case (code)
         `LPD_BL2: return `LPD_BEATS2;
         `LPD_BL4: return `LPD_BEATS4;
         `LPD_BL8: return `LPD_BEATS8;
         `LPD_BL16: return `LPD_BEATS16;
         default: return `LPD_BEATS2;
      endcase
   endfunction

endpackage

`default_nettype wire

/* File: rtl/lpd_if.sv */
/*
 Pin bundle between controller and memory, one modport per end.
 Two-way pins are resolved here from each end's output enable; an
 undriven data or strobe wire reads low, as with a weak pull-down.
*/
`default_nettype none

interface lpd_if;
   logic diff_clk_true;
   logic diff_clk_comp;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic array_group_sel0;
   logic array_group_sel1;
   logic [12:0] addr;
   logic low_byte_mask;
   logic high_byte_mask;
   logic [15:0] h_dq_o;
   logic [1:0] h_dqs_o;
   logic h_oe_n;
   logic [15:0] d_dq_o;
   logic [1:0] d_dqs_o;
   logic d_oe_n;
   wire logic [15:0] dq;
   wire logic low_byte_strobe;
   wire logic high_byte_strobe;

   // Memory drive wins; nobody driving reads as zero
   assign dq = !d_oe_n ? d_dq_o : (!h_oe_n ? h_dq_o : 16'h0000);
   assign low_byte_strobe = !d_oe_n ? d_dqs_o[0] : (!h_oe_n & h_dqs_o[0]);
   assign high_byte_strobe = !d_oe_n ? d_dqs_o[1] : (!h_oe_n & h_dqs_o[1]);

   modport ctrl (
      output diff_clk_true, diff_clk_comp, cke, cs_n, ras_n, cas_n, we_n,
      output array_group_sel0, array_group_sel1, addr, low_byte_mask, high_byte_mask,
      output h_dq_o, h_dqs_o, h_oe_n,
      input dq, low_byte_strobe, high_byte_strobe
   );

   modport mem (
      input diff_clk_true, diff_clk_comp, cke, cs_n, ras_n, cas_n, we_n,
      input array_group_sel0, array_group_sel1, addr, low_byte_mask, high_byte_mask,
      output d_dq_o, d_dqs_o, d_oe_n,
      input dq, low_byte_strobe, high_byte_strobe
   );
endinterface

`default_nettype wire

/* File: rtl/lpd_lane.sv */
/*
 One byte lane of write capture: finds each strobe transition and
 registers the byte and its mask seen with it.
 Assumes strobe, data and mask are synchronous to clk.
*/
`default_nettype none

module lpd_lane (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic strobe,
   input wire logic [7:0] data,
   input wire logic mask,
   output logic beat,
   output logic [7:0] wr_byte,
   output logic wr_mask
);
   logic prev_q;
   logic beat_q;
   logic [7:0] byte_q;
   logic mask_q;

   // Either strobe direction is a beat, so two beats per link cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 1'h0;
         beat_q <= 1'h0;
         byte_q <= 8'h00;
         mask_q <= 1'h1;
      end else begin
         prev_q <= strobe;
         beat_q <= strobe ^ prev_q;
         byte_q <= data;
         mask_q <= mask;
      end
   end

   assign beat = beat_q;
   assign wr_byte = byte_q;
   assign wr_mask = mask_q;
endmodule

`default_nettype wire

/* File: rtl/lpd_mem.sv */
/*
 Memory end of the link: command decode, bank and row tracking, mode
 register, burst engine, small storage array and power states.
 Assumes the controller end keeps its side of the protocol and that all
 link pins change synchronously to clk.
*/
`default_nettype none
`include "lpd_regs.svh"

module lpd_mem
   import lpd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   lpd_if.mem pins,
   output var lpd_pwr_e pwr_state,
   output logic [3:0] bank_open,
   output logic [6:0] mode_word
);
   logic ck_prev_q;
   logic rise;
   logic run;
   logic take;
   logic [2:0] cmd;
   logic [1:0] bank;
   logic autopre_flag;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_mrs;
   logic is_bst;
   logic restart;
   logic sref_go;
   logic dpd_go;
   lpd_pwr_e pwr_q;
   logic [6:0] mode_q;
   logic [3:0] open_q;
   logic [1:0] row_q [4];
   logic [15:0] mem_q [`LPD_MEM_DEPTH];
   logic [4:0] beats;
   logic [1:0] bst_bank_q;
   logic [3:0] bst_col_q;
   logic [3:0] beat_q;
   logic [2:0] rd_wait_q;
   logic [4:0] rd_left_q;
   logic [4:0] wr_left_q;
   logic ap_q;
   logic rd_beat;
   logic wr_beat;
   logic ap_done;
   logic [7:0] cur_idx;
   logic [15:0] dq_q;
   logic dqs_q;
   logic oe_n_q;
   logic [1:0] ln_beat;
   logic [7:0] ln_byte [2];
   logic [1:0] ln_mask;
   logic [1:0] ln_strobe;
   logic [1:0] ln_mask_in;

   // Column of a beat inside its wrapped block, either burst order
   function automatic logic [3:0] beat_col(input logic [3:0] col, input logic [3:0] i,
                                           input logic [4:0] n, input logic il);
      logic [3:0] m;
      m = 4'(n - 5'h01);
      return il ? (col ^ i) : ((col & ~m) | ((col + i) & m));
   endfunction

   // Crossing detect: previous true-clock level kept for the rising edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ck_prev_q <= 1'h0;
      end else begin
         ck_prev_q <= pins.diff_clk_true;
      end
   end

   assign rise = pins.diff_clk_true & ~pins.diff_clk_comp & ~ck_prev_q;
   assign run = (pwr_q == LPD_RUN);
   assign cmd = {pins.ras_n, pins.cas_n, pins.we_n};
   assign bank = {pins.array_group_sel1, pins.array_group_sel0};
   assign autopre_flag = pins.addr[`LPD_AP_BIT];
   // Outside run state every command pin is ignored
   assign take = rise & run & pins.cke & ~pins.cs_n;
   assign is_act = take & (cmd == `LPD_CMD_ACT);
   assign is_rd = take & (cmd == `LPD_CMD_RD);
   assign is_wr = take & (cmd == `LPD_CMD_WR);
   assign is_pre = take & (cmd == `LPD_CMD_PRE);
   assign is_mrs = take & (cmd == `LPD_CMD_MRS);
   assign is_bst = take & (cmd == `LPD_CMD_BST);
   assign restart = is_rd | is_wr | is_bst;
   // Refresh or terminate with clock gate low and all banks idle
   assign sref_go = rise & run & ~pins.cke & ~pins.cs_n & (cmd == `LPD_CMD_REF)
                    & (open_q == 4'h0);
   assign dpd_go = rise & run & ~pins.cke & ~pins.cs_n & (cmd == `LPD_CMD_BST)
                   & (open_q == 4'h0);

   // Power states: entry and most exits only at a rising crossing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_q <= LPD_RUN;
      end else begin
         unique case (pwr_q)
            LPD_RUN: begin
               if (sref_go)
                  pwr_q <= LPD_SREF;
               else if (dpd_go)
                  pwr_q <= LPD_DPD;
               else if (rise && !pins.cke)
                  pwr_q <= (open_q != 4'h0) ? LPD_APD : LPD_PPD;
            end
            LPD_APD, LPD_PPD, LPD_DPD: begin
               if (rise && pins.cke)
                  pwr_q <= LPD_RUN;
            end
            LPD_SREF: begin
               // Exit does not wait for a crossing: clock may still be stopped
               if (pins.cke)
                  pwr_q <= LPD_RUN;
            end
         endcase
      end
   end

   // Base mode register; deep power down forgets it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= `LPD_MR_RST;
      end else if (dpd_go) begin
         mode_q <= `LPD_MR_RST;
      end else if (is_mrs && bank == `LPD_BANK_BASE) begin
         mode_q <= pins.addr[6:0];
      end
   end

   assign beats = lpd_beats(mode_q[`LPD_MR_BL]);

   // Open-bank flags; auto precharge closes a bank when its burst ends
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         open_q <= 4'h0;
      end else begin
         if (ap_done)
            open_q[bst_bank_q] <= 1'h0;
         if (is_act)
            open_q[bank] <= 1'h1;
         else if (is_pre && autopre_flag)
            open_q <= 4'h0;
         else if (is_pre)
            open_q[bank] <= 1'h0;
      end
   end

   // Row of each bank; only the low bits reach the small array
   always_ff @(posedge clk) begin
      if (is_act)
         row_q[bank] <= pins.addr[1:0];
   end

   assign rd_beat = run & ~restart & (rd_left_q != 5'h00);
   assign wr_beat = run & ~restart & (wr_left_q != 5'h00) & ln_beat[0];
   assign ap_done = ap_q & ((rd_beat & (rd_left_q == 5'h01))
                            | (wr_beat & (wr_left_q == 5'h01)));
   assign cur_idx = {bst_bank_q, row_q[bst_bank_q],
                     beat_col(bst_col_q, beat_q, beats, mode_q[`LPD_MR_BT])};

   // Burst engine: a new read, write or terminate cuts any burst short
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bst_bank_q <= 2'h0;
         bst_col_q <= 4'h0;
         beat_q <= 4'h0;
         rd_wait_q <= 3'h0;
         rd_left_q <= 5'h00;
         wr_left_q <= 5'h00;
         ap_q <= 1'h0;
      end else if (!run) begin
         rd_wait_q <= 3'h0;
         rd_left_q <= 5'h00;
         wr_left_q <= 5'h00;
         ap_q <= 1'h0;
      end else if (is_rd || is_wr) begin
         bst_bank_q <= bank;
         bst_col_q <= pins.addr[3:0];
         beat_q <= 4'h0;
         ap_q <= autopre_flag;
         rd_wait_q <= !is_rd ? 3'h0 : (mode_q[`LPD_MR_CL] == `LPD_CL2)
                      ? `LPD_RD_WAIT_CL2 : `LPD_RD_WAIT_CL3;
         rd_left_q <= 5'h00;
         wr_left_q <= is_wr ? beats : 5'h00;
      end else if (is_bst) begin
         rd_wait_q <= 3'h0;
         rd_left_q <= 5'h00;
         wr_left_q <= 5'h00;
         ap_q <= 1'h0;
      end else begin
         if (rd_wait_q != 3'h0)
            rd_wait_q <= rd_wait_q - 3'h1;
         if (rd_wait_q == 3'h1)
            rd_left_q <= beats;
         else if (rd_beat)
            rd_left_q <= rd_left_q - 5'h01;
         if (wr_beat)
            wr_left_q <= wr_left_q - 5'h01;
         if (rd_beat || wr_beat)
            beat_q <= beat_q + 4'h1;
         if (ap_done)
            ap_q <= 1'h0;
      end
   end

   // Read drive: one preamble cycle, then one beat per clk, strobe edge-aligned
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dq_q <= 16'h0000;
         dqs_q <= 1'h0;
         oe_n_q <= 1'h1;
      end else if (rd_beat) begin
         dq_q <= mem_q[cur_idx];
         dqs_q <= ~dqs_q;
         oe_n_q <= 1'h0;
      end else if (run && !restart && rd_wait_q == 3'h1) begin
         dq_q <= 16'h0000;
         dqs_q <= 1'h0;
         oe_n_q <= 1'h0;
      end else begin
         dqs_q <= 1'h0;
         oe_n_q <= 1'h1;
      end
   end

   assign ln_strobe = {pins.high_byte_strobe, pins.low_byte_strobe};
   assign ln_mask_in = {pins.high_byte_mask, pins.low_byte_mask};

   // One capture lane per byte, each on its own strobe and mask
   for (genvar g = 0; g < `LPD_LANES; g++) begin : g_lane
      lpd_lane u_lane (
         .clk(clk),
         .reset_n(reset_n),
         .strobe(ln_strobe[g]),
         .data(pins.dq[8*g +: 8]),
         .mask(ln_mask_in[g]),
         .beat(ln_beat[g]),
         .wr_byte(ln_byte[g]),
         .wr_mask(ln_mask[g])
      );
   end

   // Array write; a masked byte keeps its old contents
   always_ff @(posedge clk) begin
      if (wr_beat) begin
         for (int i = 0; i < `LPD_LANES; i++) begin
            if (!ln_mask[i])
               mem_q[cur_idx][8*i +: 8] <= ln_byte[i];
         end
      end
   end

   assign pins.d_dq_o = dq_q;
   assign pins.d_dqs_o = {dqs_q, dqs_q};
   assign pins.d_oe_n = oe_n_q;
   assign pwr_state = pwr_q;
   assign bank_open = open_q;
   assign mode_word = mode_q;
endmodule

`default_nettype wire

/* File: rtl/lpd_ctrl.sv */
/*
 Controller end of the link: makes the differential clock by dividing
 clk by two, issues one request per link cycle, drives write bursts and
 returns read beats.
 Assumes the user keeps wr_data valid whenever wr_pull is high.
*/
`default_nettype none
`include "lpd_regs.svh"

module lpd_ctrl
   import lpd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   lpd_if.ctrl pins,
   input wire logic req_valid,
   input var lpd_req_e req_cmd,
   input wire logic [1:0] req_bank,
   input wire logic [12:0] req_addr,
   input wire logic cke_req,
   output logic req_ready,
   output logic wr_pull,
   input wire logic [15:0] wr_data,
   input wire logic [1:0] wr_mask,
   output logic rd_valid,
   output logic [15:0] rd_data
);
   logic ck_q;
   logic rdy_q;
   logic take;
   logic cke_q;
   logic cs_n_q;
   logic [2:0] rcw_q;
   logic [1:0] ba_q;
   logic [12:0] addr_q;
   logic [4:0] beats_q;
   logic [4:0] wr_left_q;
   logic pull_q;
   logic [15:0] dq_q;
   logic [1:0] dm_q;
   logic dqs_q;
   logic oe_n_q;
   logic strb_prev_q;
   logic rd_valid_q;
   logic [15:0] rd_data_q;

   function automatic logic [2:0] code_of(input lpd_req_e r);
      unique case (r)
         LPD_Q_NOP: return `LPD_CMD_NOP;
         LPD_Q_ACT: return `LPD_CMD_ACT;
         LPD_Q_RD: return `LPD_CMD_RD;
         LPD_Q_WR: return `LPD_CMD_WR;
         LPD_Q_PRE: return `LPD_CMD_PRE;
         LPD_Q_REF: return `LPD_CMD_REF;
         LPD_Q_MRS: return `LPD_CMD_MRS;
         LPD_Q_BST: return `LPD_CMD_BST;
      endcase
   endfunction

   assign take = req_valid & rdy_q;

   // Link clock and request slot: one slot per link cycle, none during writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ck_q <= 1'h0;
         rdy_q <= 1'h0;
      end else begin
         ck_q <= ~ck_q;
         rdy_q <= ~ck_q & (wr_left_q == 5'h00);
      end
   end

   // Command pins change only as the true clock falls, stable at the rise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cke_q <= 1'h1;
         cs_n_q <= 1'h1;
         rcw_q <= `LPD_CMD_NOP;
         ba_q <= 2'h0;
         addr_q <= 13'h0000;
      end else if (ck_q) begin
         cke_q <= cke_req;
         cs_n_q <= 1'h0;
         rcw_q <= take ? code_of(req_cmd) : `LPD_CMD_NOP;
         ba_q <= req_bank;
         addr_q <= req_addr;
      end
   end

   // Burst length follows each base mode register write issued
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         beats_q <= `LPD_BEATS2;
      else if (take && req_cmd == LPD_Q_MRS && req_bank == `LPD_BANK_BASE)
         beats_q <= lpd_beats(req_addr[`LPD_MR_BL]);
   end

   // Write burst: preamble cycle, then a beat per clk with a strobe toggle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_left_q <= 5'h00;
         pull_q <= 1'h0;
         dq_q <= 16'h0000;
         dm_q <= 2'h3;
         dqs_q <= 1'h0;
         oe_n_q <= 1'h1;
      end else if (take && req_cmd == LPD_Q_WR) begin
         wr_left_q <= beats_q;
         pull_q <= 1'h1;
         dqs_q <= 1'h0;
         oe_n_q <= 1'h0;
      end else if (wr_left_q != 5'h00) begin
         wr_left_q <= wr_left_q - 5'h01;
         pull_q <= (wr_left_q > 5'h01);
         dq_q <= wr_data;
         dm_q <= wr_mask;
         dqs_q <= ~dqs_q;
      end else begin
         pull_q <= 1'h0;
         dm_q <= 2'h3;
         dqs_q <= 1'h0;
         oe_n_q <= 1'h1;
      end
   end

   // Read return: each strobe transition from the memory is one beat
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strb_prev_q <= 1'h0;
         rd_valid_q <= 1'h0;
         rd_data_q <= 16'h0000;
      end else begin
         strb_prev_q <= pins.low_byte_strobe;
         rd_valid_q <= oe_n_q & (pins.low_byte_strobe ^ strb_prev_q);
         rd_data_q <= pins.dq;
      end
   end

   assign pins.diff_clk_true = ck_q;
   assign pins.diff_clk_comp = ~ck_q;
   assign pins.cke = cke_q;
   assign pins.cs_n = cs_n_q;
   assign pins.ras_n = rcw_q[2];
   assign pins.cas_n = rcw_q[1];
   assign pins.we_n = rcw_q[0];
   assign pins.array_group_sel0 = ba_q[0];
   assign pins.array_group_sel1 = ba_q[1];
   assign pins.addr = addr_q;
   assign pins.low_byte_mask = dm_q[0];
   assign pins.high_byte_mask = dm_q[1];
   assign pins.h_dq_o = dq_q;
   assign pins.h_dqs_o = {dqs_q, dqs_q};
   assign pins.h_oe_n = oe_n_q;
   assign req_ready = rdy_q;
   assign wr_pull = pull_q;
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
endmodule

`default_nettype wire

/* File: sim/lpd_monitor.sv */
/*
 Checker on the link pins between the controller and memory ends.
 Assumes instantiation in the bench top beside lpd_if, one clk domain.
*/
`default_nettype none

module lpd_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic diff_clk_true,
   input wire logic diff_clk_comp,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic array_group_sel0,
   input wire logic array_group_sel1,
   input wire logic [12:0] addr,
   input wire logic h_oe_n,
   input wire logic d_oe_n,
   input wire logic low_byte_strobe,
   input wire logic high_byte_strobe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic rd_take;

   // Read at a rising crossing; power state is not visible here, so a superset
   assign rd_take = diff_clk_true & cke & !cs_n & ({ras_n, cas_n, we_n} == 3'b101);

   // Link clock and complement
   // The first edge after release still sees the reset level on both sides
   property p_ck_toggle; $past(reset_n) |-> diff_clk_true != $past(diff_clk_true); endproperty
   a_ck_toggle: assert property (p_ck_toggle) else $error("link clock stuck");
   property p_ck_comp; diff_clk_comp == !diff_clk_true; endproperty
   a_ck_comp: assert property (p_ck_comp) else $error("clock pair not inverse");
   // Command pins change only when the true clock falls, so they hold at sampling
   property p_cmd_stable;
      diff_clk_true && $past(reset_n) |-> $stable({cs_n, ras_n, cas_n, we_n,
         array_group_sel0, array_group_sel1, addr});
   endproperty
   a_cmd_stable: assert property (p_cmd_stable) else $error("command moved");
   // Data pins never driven from both ends
   property p_oe_excl; d_oe_n || h_oe_n; endproperty
   a_oe_excl: assert property (p_oe_excl) else $error("both ends drive");
   // Memory drives only after a read: CL2 or CL3 wait, plus the clk the fall is seen in
   property p_rd_cause; $fell(d_oe_n) |-> $past(rd_take, 4) || $past(rd_take, 6); endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("drive without read");
   property p_rd_bound; $fell(d_oe_n) |-> ##[1:20] d_oe_n; endproperty
   a_rd_bound: assert property (p_rd_bound) else $error("pins not released");
   // Read strobes toggle each beat and both lanes agree
   property p_rd_strobe;
      !d_oe_n && !$past(d_oe_n) |->
         low_byte_strobe != $past(low_byte_strobe) && high_byte_strobe == low_byte_strobe;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe wrong");
   property p_wr_start; $fell(h_oe_n) |-> !cs_n && {ras_n, cas_n, we_n} == 3'b100; endproperty
   a_wr_start: assert property (p_wr_start) else $error("write drive w/o write");

   c_read: cover property (rd_take);
   c_write: cover property ($fell(h_oe_n));
   c_gate: cover property ($fell(cke));
endmodule

`default_nettype wire

/* File: sim/ddr_sdram_pin_interface_tb.sv */
/*
 Bench joining both link ends: mode register, masked writes, reads at
 two latencies with the CL2 one wrapping, auto precharge and power states.
 Assumes rtl/ is compiled first and lpd_regs.svh is on the include path.
*/
`default_nettype none

module ddr_sdram_pin_interface_tb
   import lpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, req_valid, cke_req, req_ready, wr_pull, rd_valid;
   lpd_req_e req_cmd;
   lpd_pwr_e pwr_state;
   logic [1:0] req_bank, wr_mask;
   logic [12:0] req_addr;
   logic [15:0] wr_data, rd_data;
   logic [3:0] bank_open;
   logic [6:0] mode_word;
   logic [15:0] wq[2];
   logic [15:0] rq[2];
   logic [1:0] mq[2];
   int miscompares, checked, nrd;

   lpd_if link();

   lpd_ctrl u_lpd_ctrl (.clk(clk), .reset_n(reset_n), .pins(link), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .cke_req(cke_req),
      .req_ready(req_ready), .wr_pull(wr_pull), .wr_data(wr_data), .wr_mask(wr_mask),
      .rd_valid(rd_valid), .rd_data(rd_data));
   lpd_mem u_lpd_mem (.clk(clk), .reset_n(reset_n), .pins(link), .pwr_state(pwr_state),
      .bank_open(bank_open), .mode_word(mode_word));
   lpd_monitor u_lpd_monitor (.clk(clk), .reset_n(reset_n),
      .diff_clk_true(link.diff_clk_true), .diff_clk_comp(link.diff_clk_comp),
      .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
      .we_n(link.we_n), .array_group_sel0(link.array_group_sel0),
      .array_group_sel1(link.array_group_sel1), .addr(link.addr), .h_oe_n(link.h_oe_n),
      .d_oe_n(link.d_oe_n), .low_byte_strobe(link.low_byte_strobe),
      .high_byte_strobe(link.high_byte_strobe));

   // 200 MHz clock
   always #2.5 clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One request; then 16 cycles feeding write beats and gathering read beats
   task automatic send(input lpd_req_e c, input logic [1:0] b, input logic [12:0] a);
      int n;
      int k;
      n = 0;
      k = 0;
      nrd = 0;
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_addr = a;
      while (req_ready !== 1'b1 && n < 50) begin
         wait_n(1);
         n++;
      end
      // A request slot that never opens is a failure, not a silent skip
      if (n >= 50)
         miscompares++;
      wait_n(1);
      req_valid = 1'b0;
      repeat (16) begin
         if (wr_pull === 1'b1 && k < 2) begin
            wr_data = wq[k];
            wr_mask = mq[k];
            k++;
         end
         if (rd_valid === 1'b1 && nrd < 2) begin
            rq[nrd] = rd_data;
            nrd++;
         end
         wait_n(1);
      end
   endtask

   // Watchdog: tests take about 1.4 us, so 20 us means a hang
   initial begin
      #20000;
      miscompares++;
      give_verdict();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_cmd = LPD_Q_NOP;
      req_bank = 2'h0;
      req_addr = 13'h0000;
      cke_req = 1'b1;
      wr_data = 16'h0000;
      wr_mask = 2'h0;
      miscompares = 0;
      checked = 0;
      wait_n(8);
      reset_n = 1'b1;
      check(16'(mode_word), 16'h0000);
      check(16'(bank_open), 16'h0000);
      check(16'(pwr_state), 16'(LPD_RUN));
      $display("test reset done");
      // Burst of two, CL2; an opcode sent to bank 1 must not land
      send(LPD_Q_MRS, 2'h0, 13'h0021);
      check(16'(mode_word), 16'h0021);
      send(LPD_Q_MRS, 2'h1, 13'h0032);
      check(16'(mode_word), 16'h0021);
      $display("test mode register done");
      // Plain write, then one with a different lane masked on each beat
      send(LPD_Q_ACT, 2'h1, 13'h0000);
      check(16'(bank_open), 16'h0002);
      wq = '{16'hAAAA, 16'hBBBB};
      mq = '{2'h0, 2'h0};
      send(LPD_Q_WR, 2'h1, 13'h0000);
      wq = '{16'h1234, 16'h5678};
      mq = '{2'h2, 2'h1};
      send(LPD_Q_WR, 2'h1, 13'h0000);
      // Start at column 1 so the burst wraps
      send(LPD_Q_RD, 2'h1, 13'h0001);
      check(16'(nrd), 16'h0002);
      check(rq[0], 16'h56BB);
      check(rq[1], 16'hAA34);
      $display("test masked write done");
      // CL3 read with auto precharge closes the bank after the burst
      send(LPD_Q_MRS, 2'h0, 13'h0031);
      send(LPD_Q_RD, 2'h1, 13'h0400);
      check(16'(nrd), 16'h0002);
      check(rq[0], 16'hAA34);
      check(rq[1], 16'h56BB);
      check(16'(bank_open), 16'h0000);
      $display("test auto precharge done");
      // Gate low with a row open, then with all banks idle
      send(LPD_Q_ACT, 2'h2, 13'h0000);
      check(16'(bank_open), 16'h0004);
      cke_req = 1'b0;
      wait_n(6);
      check(16'(pwr_state), 16'(LPD_APD));
      cke_req = 1'b1;
      wait_n(6);
      check(16'(pwr_state), 16'(LPD_RUN));
      send(LPD_Q_PRE, 2'h0, 13'h0400);
      check(16'(bank_open), 16'h0000);
      cke_req = 1'b0;
      wait_n(6);
      check(16'(pwr_state), 16'(LPD_PPD));
      send(LPD_Q_MRS, 2'h0, 13'h0022);
      check(16'(mode_word), 16'h0031);
      cke_req = 1'b1;
      wait_n(6);
      check(16'(pwr_state), 16'(LPD_RUN));
      $display("test power states done");
      // Gate goes low with the command itself: refresh enters self refresh
      cke_req = 1'b0;
      send(LPD_Q_REF, 2'h0, 13'h0000);
      check(16'(pwr_state), 16'(LPD_SREF));
      cke_req = 1'b1;
      wait_n(6);
      check(16'(pwr_state), 16'(LPD_RUN));
      // Terminate with the gate low enters deep power down and forgets the mode
      cke_req = 1'b0;
      send(LPD_Q_BST, 2'h0, 13'h0000);
      check(16'(pwr_state), 16'(LPD_DPD));
      check(16'(mode_word), 16'h0000);
      cke_req = 1'b1;
      wait_n(6);
      check(16'(pwr_state), 16'(LPD_RUN));
      $display("test self refresh done");
      give_verdict();
   end
endmodule

`default_nettype wire
